// file: core/bit_timer_exec.sv
`timescale 1ns/1ps
`include "bit_timer_defines.svh"

// Behaviour
// (RULE1) bit clear zeroes bit j of the data_pointer RAM nibble, others kept
// (RULE2) bit test skips next instruction when RAM bit j (0..3) is zero
// (RULE3) memory compare skips when accumulator equals RAM nibble; no register changes
// (RULE4) immediate compare skips when accumulator equals immediate 0..15
// (RULE5) timer-2 load writes pair value into timer 2 and its reload register
// (RULE6) timer-2 read copies timer 2 count into accumulator and second register
// (RULE7) period read copies pulse period register into accumulator and second register
// (RULE8) timer-4 load writes pair value into timer 4 and its reload register
// (RULE9) timer-4 load also presets timer 3 count to FF
// (RULE10) first control write copies accumulator into first timer control register
// (RULE11) flag-one test skips when flag set, then clears the flag
// (RULE12) flag-two and flag-three tests skip when set, then clear their flag
// (RULE13) pair transfers: second register holds bits 7..4, accumulator bits 3..0
// (RULE14) second and third control writes load second and third control registers
// (RULE15) jump replaces low seven PC bits; far_jump also loads page bits
module bit_timer_exec
    import bit_timer_pkg::*;
(
    input  wire logic        i_ref_clk,
    input  wire logic        i_sys_rst,
    input  wire logic        i_exec,
    input  wire op_t         i_op,
    input  wire logic [3:0]  i_imm,
    input  wire logic [6:0]  i_addr,
    input  wire logic [2:0]  i_page,
    input  wire logic [9:0]  i_pc,
    input  wire logic [3:0]  i_acc,
    input  wire logic [3:0]  i_breg,
    input  wire logic [3:0]  i_ram_rdata,
    input  wire logic [7:0]  i_timer2_count,
    input  wire logic [7:0]  i_period,
    input  wire logic [2:0]  i_flag_set,
    output logic             o_skip,
    output logic             o_ram_we,
    output logic      [3:0]  o_ram_wdata,
    output logic             o_acc_we,
    output logic      [3:0]  o_acc_wdata,
    output logic             o_breg_we,
    output logic      [3:0]  o_breg_wdata,
    output logic             o_timer2_load,
    output logic      [7:0]  o_timer2_value,
    output logic      [7:0]  o_reload2,
    output logic             o_timer4_load,
    output logic      [7:0]  o_timer4_value,
    output logic      [7:0]  o_reload4,
    output logic             o_timer3_preset,
    output logic      [7:0]  o_timer3_value,
    output logic      [3:0]  o_ctrl_first,
    output logic      [3:0]  o_ctrl_second,
    output logic      [3:0]  o_ctrl_third,
    output logic      [2:0]  o_flags,
    output logic             o_pc_load,
    output logic      [9:0]  o_pc_value
);

    // ----------------------------------------------------------------
    // nibble arithmetic
    // ----------------------------------------------------------------
    logic [3:0] ram_cleared;
    logic       bit_zero;
    logic       eq_mem;
    logic       eq_imm;

    nibble_ops u_nibble_ops
    (
        .i_ram      (i_ram_rdata),
        .i_acc      (i_acc),
        .i_imm      (i_imm),
        .o_cleared  (ram_cleared),
        .o_bit_zero (bit_zero),
        .o_eq_mem   (eq_mem),
        .o_eq_imm   (eq_imm)
    );

    // ----------------------------------------------------------------
    // instruction decode
    // ----------------------------------------------------------------
    wire        do_clear    = i_exec && (i_op == op_bit_clear);
    wire        do_test     = i_exec && (i_op == op_bit_test);
    wire        do_cmp_mem  = i_exec && (i_op == op_cmp_mem);
    wire        do_cmp_imm  = i_exec && (i_op == op_cmp_imm);
    wire        do_ld_t2    = i_exec && (i_op == load_timer_two_pair);
    wire        do_rd_t2    = i_exec && (i_op == read_timer_two_pair);
    wire        do_rd_per   = i_exec && (i_op == read_period_pair);
    wire        do_ld_t4    = i_exec && (i_op == load_timer_four_pair);
    wire        do_ctrl1    = i_exec && (i_op == write_ctrl_first);
    wire        do_ctrl2    = i_exec && (i_op == write_ctrl_second);
    wire        do_ctrl3    = i_exec && (i_op == write_ctrl_third);
    wire        do_jump     = i_exec && (i_op == op_jump);
    wire        do_far      = i_exec && (i_op == far_jump);
    wire [2:0]  do_flag_tst = {i_exec && (i_op == test_clear_flag_three),
                               i_exec && (i_op == test_clear_flag_two),
                               i_exec && (i_op == test_clear_flag_one)};

    // pair value: second register high, accumulator low
    wire [7:0]  pair_value  = {i_breg, i_acc};                        // RULE13
    // source of a read into the pair
    wire [7:0]  read_value  = do_rd_per ? i_period : i_timer2_count;   // RULE6 RULE7
    wire        do_read     = do_rd_t2 || do_rd_per;

    // ----------------------------------------------------------------
    // skip decision
    // ----------------------------------------------------------------
    wire        skip_bit    = do_test && bit_zero;                   // RULE2
    wire        skip_mem    = do_cmp_mem && eq_mem;                  // RULE3
    wire        skip_imm    = do_cmp_imm && eq_imm;                  // RULE4
    wire        skip_flag   = |(do_flag_tst & o_flags);              // RULE11 RULE12
    wire        next_skip   = skip_bit || skip_mem || skip_imm || skip_flag;

    // ----------------------------------------------------------------
    // jump target
    // ----------------------------------------------------------------
    wire [2:0]  next_page   = do_far ? i_page : i_pc[9:7];            // RULE15
    wire [9:0]  next_pc     = {next_page, i_addr};                   // RULE15

    // ----------------------------------------------------------------
    // flags: hardware set wins over test clear
    // ----------------------------------------------------------------
    wire [2:0]  next_flags  = i_flag_set | (o_flags & ~do_flag_tst);  // RULE11 RULE12

    // ----------------------------------------------------------------
    // one-cycle strobes
    // ----------------------------------------------------------------
    always_ff @(posedge i_ref_clk)
    begin
        if (i_sys_rst)
        begin
            o_skip          <= 1'b0;
            o_ram_we        <= 1'b0;
            o_acc_we        <= 1'b0;
            o_breg_we       <= 1'b0;
            o_timer2_load   <= 1'b0;
            o_timer4_load   <= 1'b0;
            o_timer3_preset <= 1'b0;
            o_pc_load       <= 1'b0;
        end
        else
        begin
            o_skip          <= next_skip;
            o_ram_we        <= do_clear;          // RULE1
            o_acc_we        <= do_read;           // RULE6 RULE7
            o_breg_we       <= do_read;           // RULE6 RULE7
            o_timer2_load   <= do_ld_t2;          // RULE5
            o_timer4_load   <= do_ld_t4;          // RULE8
            o_timer3_preset <= do_ld_t4;          // RULE9
            o_pc_load       <= do_jump || do_far; // RULE15
        end
    end

    // ----------------------------------------------------------------
    // data paths to RAM, pair and program counter
    // ----------------------------------------------------------------
    always_ff @(posedge i_ref_clk)
    begin
        if (i_sys_rst)
        begin
            o_ram_wdata  <= `NIBBLE_RESET;
            o_acc_wdata  <= `NIBBLE_RESET;
            o_breg_wdata <= `NIBBLE_RESET;
            o_pc_value   <= `PC_RESET;
        end
        else
        begin
            if (do_clear)
                o_ram_wdata <= ram_cleared;        // RULE1
            if (do_read)
            begin
                o_acc_wdata  <= read_value[3:0];   // RULE13
                o_breg_wdata <= read_value[7:4];   // RULE13
            end
            if (do_jump || do_far)
                o_pc_value <= next_pc;             // RULE15
        end
    end

    // ----------------------------------------------------------------
    // timer load values and reload registers
    // ----------------------------------------------------------------
    always_ff @(posedge i_ref_clk)
    begin
        if (i_sys_rst)
        begin
            o_timer2_value <= `BYTE_RESET;
            o_reload2      <= `BYTE_RESET;
            o_timer4_value <= `BYTE_RESET;
            o_reload4      <= `BYTE_RESET;
            o_timer3_value <= `TIMER3_PRESET;
        end
        else
        begin
            if (do_ld_t2)
            begin
                o_timer2_value <= pair_value;      // RULE5
                o_reload2      <= pair_value;      // RULE5
            end
            if (do_ld_t4)
            begin
                o_timer4_value <= pair_value;      // RULE8
                o_reload4      <= pair_value;      // RULE8
                o_timer3_value <= `TIMER3_PRESET;  // RULE9
            end
        end
    end

    // ----------------------------------------------------------------
    // timer control registers
    // ----------------------------------------------------------------
    always_ff @(posedge i_ref_clk)
    begin
        if (i_sys_rst)
        begin
            o_ctrl_first  <= `NIBBLE_RESET;
            o_ctrl_second <= `NIBBLE_RESET;
            o_ctrl_third  <= `NIBBLE_RESET;
        end
        else
        begin
            if (do_ctrl1)
                o_ctrl_first <= i_acc;             // RULE10
            if (do_ctrl2)
                o_ctrl_second <= i_acc;            // RULE14
            if (do_ctrl3)
                o_ctrl_third <= i_acc;             // RULE14
        end
    end

    // ----------------------------------------------------------------
    // timer flags
    // ----------------------------------------------------------------
    always_ff @(posedge i_ref_clk)
    begin
        if (i_sys_rst)
            o_flags <= `FLAGS_RESET;
        else
            o_flags <= next_flags;                 // RULE11 RULE12
    end

endmodule : bit_timer_exec

// file: core/nibble_ops.sv
`timescale 1ns/1ps
`include "bit_timer_defines.svh"

module nibble_ops
(
    input  wire logic [3:0] i_ram,
    input  wire logic [3:0] i_acc,
    input  wire logic [3:0] i_imm,
    output logic      [3:0] o_cleared,
    output logic            o_bit_zero,
    output logic            o_eq_mem,
    output logic            o_eq_imm
);

    // ----------------------------------------------------------------
    // per-bit clear: only the bit named by imm[1:0] is forced low
    // ----------------------------------------------------------------
    genvar b;
    generate
        for (b = 0; b < `NIBBLE_W; b = b + 1)
        begin : g_clear
            assign o_cleared[b] = i_ram[b] & (i_imm[1:0] != 2'(b));  // RULE1
        end
    endgenerate

    // ----------------------------------------------------------------
    // skip conditions
    // ----------------------------------------------------------------
    assign o_bit_zero = ~i_ram[i_imm[1:0]];      // RULE2
    assign o_eq_mem   = (i_acc == i_ram);        // RULE3
    assign o_eq_imm   = (i_acc == i_imm);        // RULE4

endmodule : nibble_ops

// file: inc/bit_timer_defines.svh
`ifndef BIT_TIMER_DEFINES_SVH
`define BIT_TIMER_DEFINES_SVH

// ----------------------------------------------------------------
// widths
// ----------------------------------------------------------------
`define NIBBLE_W        4
`define BYTE_W          8
`define PC_LOW_W        7
`define PC_PAGE_W       3
`define FLAG_COUNT      3

// ----------------------------------------------------------------
// reset and preset values
// ----------------------------------------------------------------
`define NIBBLE_RESET    4'h0
`define BYTE_RESET      8'h00
`define PC_RESET        10'h000
`define TIMER3_PRESET   8'hFF
`define FLAGS_RESET     3'h0

`endif

// file: inc/bit_timer_pkg.sv
package bit_timer_pkg;

    // ----------------------------------------------------------------
    // decoded instruction selector, one code per executed operation
    // ----------------------------------------------------------------
    typedef enum logic [4:0] {
        op_none               = 5'h00,
        op_bit_clear          = 5'h01,
        op_bit_test           = 5'h02,
        op_cmp_mem            = 5'h03,
        op_cmp_imm            = 5'h04,
        load_timer_two_pair   = 5'h05,
        read_timer_two_pair   = 5'h06,
        read_period_pair      = 5'h07,
        load_timer_four_pair  = 5'h08,
        write_ctrl_first      = 5'h09,
        write_ctrl_second     = 5'h0A,
        write_ctrl_third      = 5'h0B,
        test_clear_flag_one   = 5'h0C,
        test_clear_flag_two   = 5'h0D,
        test_clear_flag_three = 5'h0E,
        op_jump               = 5'h0F,
        far_jump              = 5'h10
    } op_t;

endpackage : bit_timer_pkg

// file: verification/bit_timer_exec_asserts.sv
`timescale 1ns/1ps
module bit_timer_exec_asserts
    import bit_timer_pkg::*;
(
    input wire logic       i_ref_clk,
    input wire logic       i_sys_rst,
    input wire logic       i_exec,
    input wire op_t        i_op,
    input wire logic [3:0] i_imm,
    input wire logic [3:0] i_acc,
    input wire logic [3:0] i_breg,
    input wire logic [3:0] i_ram_rdata,
    input wire logic [7:0] i_timer2_count,
    input wire logic [2:0] i_flag_set,
    input wire logic       o_skip,
    input wire logic       o_ram_we,
    input wire logic [3:0] o_ram_wdata,
    input wire logic       o_acc_we,
    input wire logic [3:0] o_acc_wdata,
    input wire logic       o_breg_we,
    input wire logic [3:0] o_breg_wdata,
    input wire logic       o_timer2_load,
    input wire logic [7:0] o_reload2,
    input wire logic       o_timer4_load,
    input wire logic [7:0] o_reload4,
    input wire logic       o_timer3_preset,
    input wire logic [7:0] o_timer3_value,
    input wire logic [2:0] o_flags
);
    // ----------------------------------------------------------------
    // clocking and selected-bit mask
    // ----------------------------------------------------------------
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_sys_rst);
    logic [3:0] bit_mask;
    assign bit_mask = 4'h1 << i_imm[1:0];

    // ----------------------------------------------------------------
    // instruction results one cycle after the strobe
    // ----------------------------------------------------------------
    bit_clear_a: assert property (i_exec && i_op == op_bit_clear |=>
        o_ram_we && o_ram_wdata == ($past(i_ram_rdata) & ~$past(bit_mask))) else $error("bit clear wrong");
    bit_test_a: assert property (i_exec && i_op == op_bit_test |-> ##1
        o_skip == ~|($past(i_ram_rdata) & $past(bit_mask))) else $error("bit test skip wrong");
    cmp_mem_a: assert property (i_exec && i_op == op_cmp_mem |=>
        o_skip == ($past(i_acc) == $past(i_ram_rdata)) && !o_acc_we && !o_breg_we && !o_ram_we)
        else $error("memory compare wrong");
    cmp_imm_a: assert property (i_exec && i_op == op_cmp_imm |=>
        o_skip == ($past(i_acc) == $past(i_imm))) else $error("immediate compare wrong");
    t2_load_a: assert property (i_exec && i_op == load_timer_two_pair |=>
        o_timer2_load && o_reload2 == $past({i_breg, i_acc})) else $error("timer two load wrong");
    t2_read_a: assert property (i_exec && i_op == read_timer_two_pair |=>
        o_acc_we && o_breg_we && {o_breg_wdata, o_acc_wdata} == $past(i_timer2_count))
        else $error("timer two read wrong");
    t4_load_a: assert property (i_exec && i_op == load_timer_four_pair |=>
        o_timer4_load && o_timer3_preset && o_timer3_value == 8'hFF && o_reload4 == $past({i_breg, i_acc}))
        else $error("timer four load wrong");
    flag_one_a: assert property (i_exec && i_op == test_clear_flag_one && !i_flag_set[0] |=>
        o_skip == $past(o_flags[0]) && !o_flags[0]) else $error("flag one test wrong");

    // ----------------------------------------------------------------
    // scenario coverage
    // ----------------------------------------------------------------
    cover property (o_timer3_preset);
    cover property (o_skip && o_flags == 3'h0);
    cover property (o_ram_we);
endmodule : bit_timer_exec_asserts

bind bit_timer_exec bit_timer_exec_asserts i_chk (.i_ref_clk, .i_sys_rst, .i_exec, .i_op, .i_imm, .i_acc, .i_breg,
    .i_ram_rdata, .i_timer2_count, .i_flag_set, .o_skip, .o_ram_we, .o_ram_wdata, .o_acc_we, .o_acc_wdata,
    .o_breg_we, .o_breg_wdata, .o_timer2_load, .o_reload2, .o_timer4_load, .o_reload4, .o_timer3_preset,
    .o_timer3_value, .o_flags);

// file: verification/bit_timer_exec_tb.sv
`timescale 1ns/1ps
`define CHK(got, exp) tests_run++; if ((got) !== (exp)) begin failures++; $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); end
module bit_timer_exec_tb;
    import bit_timer_pkg::*;
    logic       i_ref_clk, i_sys_rst, i_exec;
    op_t        i_op;
    logic [3:0] i_imm, i_acc, i_breg, i_ram_rdata;
    logic [7:0] i_timer2_count, i_period;
    logic [6:0] i_addr;
    logic [2:0] i_page, i_flag_set;
    logic [9:0] i_pc;
    logic       o_skip, o_ram_we, o_acc_we, o_breg_we, o_timer2_load, o_timer4_load, o_timer3_preset, o_pc_load;
    logic [3:0] o_ram_wdata, o_acc_wdata, o_breg_wdata, o_ctrl_first, o_ctrl_second, o_ctrl_third;
    logic [7:0] o_timer2_value, o_reload2, o_timer4_value, o_reload4, o_timer3_value;
    logic [2:0] o_flags;
    logic [9:0] o_pc_value;
    int         failures, tests_run;

    bit_timer_exec i_dut (.i_ref_clk, .i_sys_rst, .i_exec, .i_op, .i_imm, .i_addr, .i_page, .i_pc, .i_acc, .i_breg,
        .i_ram_rdata, .i_timer2_count, .i_period, .i_flag_set, .o_skip, .o_ram_we, .o_ram_wdata, .o_acc_we,
        .o_acc_wdata, .o_breg_we, .o_breg_wdata, .o_timer2_load, .o_timer2_value, .o_reload2, .o_timer4_load,
        .o_timer4_value, .o_reload4, .o_timer3_preset, .o_timer3_value, .o_ctrl_first, .o_ctrl_second,
        .o_ctrl_third, .o_flags, .o_pc_load, .o_pc_value);

    // ----------------------------------------------------------------
    // clock, watchdog and verdict
    // ----------------------------------------------------------------
    initial begin
        i_ref_clk = 1'b0;
        forever #12.5 i_ref_clk = ~i_ref_clk;
    end
    initial begin
        repeat (5000) @(posedge i_ref_clk);
        failures++;
        summarize();
    end
    task automatic summarize();
        $display("failures=%0d tests_run=%0d", failures, tests_run);
        if (failures == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : summarize

    // one instruction: strobe for one cycle, results settled just after the taking edge
    task automatic run_op(input op_t op, input logic [3:0] a, input logic [3:0] b, input logic [3:0] r,
                          input logic [3:0] n);
        @(posedge i_ref_clk);
        i_exec <= 1'b1;
        i_op <= op;
        i_acc <= a;
        i_breg <= b;
        i_ram_rdata <= r;
        i_imm <= n;
        @(posedge i_ref_clk);
        i_exec <= 1'b0;
        #1;
    endtask : run_op

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_bits();
        for (int j = 0; j < 4; j++)
        begin
            run_op(op_bit_clear, 4'h0, 4'h0, 4'hF, 4'(j));
            `CHK({o_ram_we, o_ram_wdata}, {1'b1, 4'hF & ~(4'h1 << j)})
            run_op(op_bit_test, 4'h0, 4'h0, ~(4'h1 << j), 4'(j));
            `CHK(o_skip, 1'b1)
            run_op(op_bit_test, 4'h0, 4'h0, 4'h1 << j, 4'(j));
            `CHK(o_skip, 1'b0)
        end
    endtask : t_bits

    task automatic t_cmp();
        run_op(op_cmp_mem, 4'h6, 4'h0, 4'h6, 4'h0);
        `CHK({o_skip, o_acc_we, o_breg_we, o_ram_we}, 4'b1000)
        run_op(op_cmp_mem, 4'h6, 4'h0, 4'h7, 4'h0);
        `CHK(o_skip, 1'b0)
        for (int n = 0; n < 16; n++)
        begin
            run_op(op_cmp_imm, 4'(n), 4'h0, 4'h0, 4'(n));
            `CHK(o_skip, 1'b1)
            run_op(op_cmp_imm, 4'(n) ^ 4'h8, 4'h0, 4'h0, 4'(n));
            `CHK(o_skip, 1'b0)
        end
    endtask : t_cmp

    task automatic t_timers();
        run_op(load_timer_two_pair, 4'h3, 4'hA, 4'h0, 4'h0);
        `CHK({o_timer2_load, o_timer2_value, o_reload2}, {1'b1, 8'hA3, 8'hA3})
        run_op(read_timer_two_pair, 4'h0, 4'h0, 4'h0, 4'h0);
        `CHK({o_acc_we, o_breg_we, o_breg_wdata, o_acc_wdata}, {2'b11, 8'h5C})
        run_op(read_period_pair, 4'h0, 4'h0, 4'h0, 4'h0);
        `CHK({o_acc_we, o_breg_we, o_breg_wdata, o_acc_wdata}, {2'b11, 8'h9E})
        run_op(load_timer_four_pair, 4'h1, 4'hE, 4'h0, 4'h0);
        `CHK({o_timer4_load, o_timer4_value, o_reload4}, {1'b1, 8'hE1, 8'hE1})
        `CHK({o_timer3_preset, o_timer3_value}, {1'b1, 8'hFF})
        `CHK(o_reload2, 8'hA3)
        run_op(write_ctrl_first, 4'h5, 4'h0, 4'h0, 4'h0);
        run_op(write_ctrl_second, 4'hA, 4'h0, 4'h0, 4'h0);
        run_op(write_ctrl_third, 4'h3, 4'h0, 4'h0, 4'h0);
        `CHK(o_ctrl_first, 4'h5)
        `CHK({o_ctrl_second, o_ctrl_third}, 8'hA3)
    endtask : t_timers

    task automatic t_flags();
        op_t tests[3] = '{test_clear_flag_one, test_clear_flag_two, test_clear_flag_three};
        for (int k = 0; k < 3; k++)
        begin
            @(posedge i_ref_clk);
            i_flag_set <= 3'h1 << k;
            @(posedge i_ref_clk);
            i_flag_set <= 3'h0;
            run_op(tests[k], 4'h0, 4'h0, 4'h0, 4'h0);
            `CHK({o_skip, o_flags}, 4'b1000)
            run_op(tests[k], 4'h0, 4'h0, 4'h0, 4'h0);
            `CHK(o_skip, 1'b0)
        end
    endtask : t_flags

    task automatic t_jump();
        run_op(op_jump, 4'h0, 4'h0, 4'h0, 4'h0);
        `CHK({o_pc_load, o_pc_value}, {1'b1, 3'h7, 7'h55})
        run_op(far_jump, 4'h0, 4'h0, 4'h0, 4'h0);
        `CHK({o_pc_load, o_pc_value}, {1'b1, 3'h2, 7'h55})
    endtask : t_jump

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        {i_sys_rst, i_exec} = 2'b10;
        i_op = op_none;
        {i_imm, i_acc, i_breg, i_ram_rdata, i_flag_set} = 19'h0_0000;
        i_timer2_count = 8'h5C;
        i_period = 8'h9E;
        i_addr = 7'h55;
        i_page = 3'h2;
        i_pc = 10'h3A0;
        repeat (6) @(posedge i_ref_clk);
        i_sys_rst <= 1'b0;
        #1;
        `CHK({o_timer3_value, o_flags, o_skip}, {8'hFF, 3'h0, 1'b0})
        t_bits();
        t_cmp();
        t_timers();
        t_flags();
        t_jump();
        summarize();
    end
endmodule : bit_timer_exec_tb
